// file: core/asmr_pkg.sv
package asmr_pkg;

  // Register addresses on page 0
  localparam logic [7:0] ASMR_PAGE_ZERO      = 8'h00;
  localparam logic [7:0] ASMR_CH3_ADDR       = 8'h0d;
  localparam logic [7:0] ASMR_CH4_ADDR       = 8'h0e;
  localparam logic [7:0] ASMR_CH5_ADDR       = 8'h0f;
  localparam logic [7:0] ASMR_CH6_ADDR       = 8'h10;

  // Values after reset
  localparam logic [7:0] ASMR_CH3_RESET      = 8'h02;
  localparam logic [7:0] ASMR_CH4_RESET      = 8'h03;
  localparam logic [7:0] ASMR_CH5_RESET      = 8'h04;
  localparam logic [7:0] ASMR_CH6_RESET      = 8'h05;

  // Field layout
  localparam int         ASMR_LINE_BIT       = 6;
  localparam int         ASMR_SLOT_MSB       = 5;
  localparam int         ASMR_SLOT_W         = 6;
  localparam int         ASMR_HALF_BIT       = 5;
  localparam logic [7:0] ASMR_WRITABLE_MASK  = 8'h7f;

  // Serial frame formats
  typedef enum logic [1:0] {
    ASMR_FMT_TDM,
    ASMR_FMT_I2S,
    ASMR_FMT_LEFT_JUSTIFIED
  } asmr_fmt_t;

endpackage : asmr_pkg

// file: core/asmr_chan_slot.sv
`timescale 1ns/1ps
// One channel slot register and its decoded placement
module asmr_chan_slot
  import asmr_pkg::*;
#(
  parameter logic [7:0] ADDR      = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00
)(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Frame format
  input  wire asmr_fmt_t  fmt,
  // Register value and placement
  output logic      [7:0] reg_q,
  output logic            line_q,
  output logic            right_q,
  output logic      [5:0] slot_q
);

  logic [7:0] reg_d;
  logic       tdm;

  // Write merges only the writable bits, bit 7 stays zero
  always_comb
  begin
    reg_d = reg_q;
    if (wr_en && wr_addr == ADDR)
    begin
      reg_d = wr_data & ASMR_WRITABLE_MASK;
    end
  end

  // Register storage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_q <= RESET_VAL;
    end
    else
    begin
      reg_q <= reg_d;
    end
  end

  assign tdm = (fmt == ASMR_FMT_TDM);

  // Decoded placement, registered
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      line_q  <= 1'b0;
      right_q <= 1'b0;
      slot_q  <= 6'h00;
    end
    else
    begin
      line_q <= reg_d[ASMR_LINE_BIT];
      if (tdm)
      begin
        right_q <= 1'b0;
        slot_q  <= reg_d[ASMR_SLOT_MSB:0];
      end
      else
      begin
        right_q <= reg_d[ASMR_HALF_BIT];
        slot_q  <= {1'b0, reg_d[ASMR_HALF_BIT-1:0]};
      end
    end
  end

  // Bit 7 stays zero after any write to this register
  property p_wr_reserved_zero;
    @(posedge ref_clk) disable iff (rst)
    $past(wr_en && wr_addr == ADDR) |-> reg_q[7] == 1'b0;
  endproperty
  a_wr_reserved_zero : assert property (p_wr_reserved_zero)
    else $error("reserved bit set after write");

  // Output line select follows the stored bit
  property p_line_follows;
    @(posedge ref_clk) disable iff (rst)
    ##1 line_q == reg_q[ASMR_LINE_BIT];
  endproperty
  a_line_follows : assert property (p_line_follows)
    else $error("line select does not follow register");

  // In TDM the slot is the field itself, never a right half
  property p_tdm_slot;
    @(posedge ref_clk) disable iff (rst)
    ($past(tdm) && !$past(rst)) |-> (slot_q == reg_q[5:0] && !right_q);
  endproperty
  a_tdm_slot : assert property (p_tdm_slot)
    else $error("tdm slot mismatch");

  // Low field values land in the left half at the same slot
  property p_left_half;
    @(posedge ref_clk) disable iff (rst)
    ($past(!tdm) && !$past(rst) && reg_q[5:0] < 6'd32)
      |-> (!right_q && slot_q == reg_q[5:0]);
  endproperty
  a_left_half : assert property (p_left_half)
    else $error("left half slot mismatch");

  // High field values land in the right half, 32 lower
  property p_right_half;
    @(posedge ref_clk) disable iff (rst)
    ($past(!tdm) && !$past(rst) && reg_q[5:0] >= 6'd32)
      |-> (right_q && slot_q == reg_q[5:0] - 6'd32);
  endproperty
  a_right_half : assert property (p_right_half)
    else $error("right half slot mismatch");

endmodule : asmr_chan_slot

// file: core/asmr_slot_map_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Bit 6 picks primary (0) or secondary (1) serial output line.
// - In TDM the 6-bit slot field is the slot number 0 to 63.
// - In I2S or left-justified, values 0-31 are left half slots.
// - In I2S or left-justified, values 32-63 are right slot value-32.
// - Channel 4 register at page 0 address 0x0e, resets to 3.
// - Channel 5 register at page 0 address 0x0f, resets to 4.
// - Channel 6 register at page 0 address 0x10, resets to 5.
// - Channel 3 register at page 0 address 0x0d, resets to 2.
module asmr_slot_map_regs
  import asmr_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Control port register access
  input  wire logic [7:0] page_sel,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Serial frame format
  input  wire asmr_fmt_t  fmt,
  // Placement of channels 3 to 6, index 0 is channel 3
  output logic      [3:0] line_sel,
  output logic      [3:0] right_half,
  output logic      [23:0] slot_num
);

  localparam logic [7:0] ADDRS [4] = '{ASMR_CH3_ADDR, ASMR_CH4_ADDR,
                                       ASMR_CH5_ADDR, ASMR_CH6_ADDR};
  localparam logic [7:0] RSTS  [4] = '{ASMR_CH3_RESET, ASMR_CH4_RESET,
                                       ASMR_CH5_RESET, ASMR_CH6_RESET};

  logic       wr_page0;
  logic [7:0] regs [4];
  logic [7:0] rdata_d;

  // Writes only reach page 0
  assign wr_page0 = reg_wr && (page_sel == ASMR_PAGE_ZERO);

  // One register per channel
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_chan
      asmr_chan_slot #(
        .ADDR      (ADDRS[gi]),
        .RESET_VAL (RSTS[gi])
      ) u_slot (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (wr_page0),
        .wr_addr (reg_addr),
        .wr_data (reg_wdata),
        .fmt     (fmt),
        .reg_q   (regs[gi]),
        .line_q  (line_sel[gi]),
        .right_q (right_half[gi]),
        .slot_q  (slot_num[gi*6 +: 6])
      );
    end
  endgenerate

  // Read decode, unmapped addresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (page_sel != ASMR_PAGE_ZERO)
    begin
      rdata_d = 8'h00;
    end
    else if (reg_addr == ASMR_CH3_ADDR)
    begin
      rdata_d = regs[0];
    end
    else if (reg_addr == ASMR_CH4_ADDR)
    begin
      rdata_d = regs[1];
    end
    else if (reg_addr == ASMR_CH5_ADDR)
    begin
      rdata_d = regs[2];
    end
    else if (reg_addr == ASMR_CH6_ADDR)
    begin
      rdata_d = regs[3];
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
  end

  // Channel 4 leaves reset at its own value
  property p_ch4_reset;
    @(posedge ref_clk)
    $fell(rst) |-> regs[1] == ASMR_CH4_RESET;
  endproperty
  a_ch4_reset : assert property (p_ch4_reset)
    else $error("channel 4 reset value wrong");

  // Channel 5 leaves reset at its own value
  property p_ch5_reset;
    @(posedge ref_clk)
    $fell(rst) |-> regs[2] == ASMR_CH5_RESET;
  endproperty
  a_ch5_reset : assert property (p_ch5_reset)
    else $error("channel 5 reset value wrong");

  // Channel 6 leaves reset with its whole byte at the reset value
  property p_ch6_reset;
    @(posedge ref_clk)
    $fell(rst) |-> regs[3] == ASMR_CH6_RESET;
  endproperty
  a_ch6_reset : assert property (p_ch6_reset)
    else $error("channel 6 reset value wrong");

  // Channel 3 leaves reset at its own value
  property p_ch3_reset;
    @(posedge ref_clk)
    $fell(rst) |-> regs[0] == ASMR_CH3_RESET;
  endproperty
  a_ch3_reset : assert property (p_ch3_reset)
    else $error("channel 3 reset value wrong");

  // A page 0 write to channel 4 lands one edge later, bit 7 dropped
  property p_ch4_rw;
    @(posedge ref_clk) disable iff (rst)
    (wr_page0 && reg_addr == ASMR_CH4_ADDR)
      |=> regs[1] == ($past(reg_wdata) & ASMR_WRITABLE_MASK);
  endproperty
  a_ch4_rw : assert property (p_ch4_rw)
    else $error("channel 4 write not stored");

  // A page 0 write to channel 5 lands one edge later, bit 7 dropped
  property p_ch5_rw;
    @(posedge ref_clk) disable iff (rst)
    (wr_page0 && reg_addr == ASMR_CH5_ADDR)
      |=> regs[2] == ($past(reg_wdata) & ASMR_WRITABLE_MASK);
  endproperty
  a_ch5_rw : assert property (p_ch5_rw)
    else $error("channel 5 write not stored");

  // A page 0 write to channel 6 lands one edge later, bit 7 dropped
  property p_ch6_rw;
    @(posedge ref_clk) disable iff (rst)
    (wr_page0 && reg_addr == ASMR_CH6_ADDR)
      |=> regs[3] == ($past(reg_wdata) & ASMR_WRITABLE_MASK);
  endproperty
  a_ch6_rw : assert property (p_ch6_rw)
    else $error("channel 6 write not stored");

  // Writes on any other page leave every slot register alone
  property p_page_wr;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && page_sel != ASMR_PAGE_ZERO)
      |=> $stable(regs[0]) && $stable(regs[1])
          && $stable(regs[2]) && $stable(regs[3]);
  endproperty
  a_page_wr : assert property (p_page_wr)
    else $error("write on another page changed a register");

  // A page 0 read of channel 3 returns the stored byte
  property p_ch3_read;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && page_sel == ASMR_PAGE_ZERO && reg_addr == ASMR_CH3_ADDR
     && !reg_wr) |=> reg_rdata == $past(regs[0]);
  endproperty
  a_ch3_read : assert property (p_ch3_read)
    else $error("channel 3 read mismatch");

  // A page 0 read of channel 4 returns the stored byte
  property p_ch4_read;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && page_sel == ASMR_PAGE_ZERO && reg_addr == ASMR_CH4_ADDR)
      |=> reg_rdata == $past(regs[1]);
  endproperty
  a_ch4_read : assert property (p_ch4_read)
    else $error("channel 4 read mismatch");

  // A page 0 read of channel 5 returns the stored byte
  property p_ch5_read;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && page_sel == ASMR_PAGE_ZERO && reg_addr == ASMR_CH5_ADDR)
      |=> reg_rdata == $past(regs[2]);
  endproperty
  a_ch5_read : assert property (p_ch5_read)
    else $error("channel 5 read mismatch");

  // A page 0 read of channel 6 returns the stored byte
  property p_ch6_read;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && page_sel == ASMR_PAGE_ZERO && reg_addr == ASMR_CH6_ADDR)
      |=> reg_rdata == $past(regs[3]);
  endproperty
  a_ch6_read : assert property (p_ch6_read)
    else $error("channel 6 read mismatch");

  // Reads on any other page return zero
  property p_page_rd;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && page_sel != ASMR_PAGE_ZERO) |=> reg_rdata == 8'h00;
  endproperty
  a_page_rd : assert property (p_page_rd)
    else $error("read on another page not zero");

  // Bit 7 never reads back as one
  property p_read_bit7;
    @(posedge ref_clk) disable iff (rst)
    $past(reg_rd) |-> reg_rdata[7] == 1'b0;
  endproperty
  a_read_bit7 : assert property (p_read_bit7)
    else $error("reserved bit read as one");

endmodule : asmr_slot_map_regs

// file: test/asmr_slot_map_regs_bench.sv
`timescale 1ns/1ps
module asmr_slot_map_regs_bench
  import asmr_pkg::*;
();
  logic        ref_clk;
  logic        rst;
  logic [7:0]  page_sel;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  asmr_fmt_t   fmt;
  logic [3:0]  line_sel;
  logic [3:0]  right_half;
  logic [23:0] slot_num;
  logic [7:0]  model [4];
  logic [31:0] seed;
  logic [31:0] r;
  int          err_count;
  int          n_tests;

  asmr_slot_map_regs dut (.ref_clk(ref_clk), .rst(rst), .page_sel(page_sel),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fmt(fmt),
    .line_sel(line_sel), .right_half(right_half), .slot_num(slot_num));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Pseudo random source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected placement outputs from the model and the format
  function automatic logic [31:0] exp_dec(asmr_fmt_t f);
    logic [3:0]  ln;
    logic [3:0]  rh;
    logic [23:0] sl;
    for (int i = 0; i < 4; i++)
    begin
      ln[i] = model[i][6];
      rh[i] = (f != ASMR_FMT_TDM) && (model[i][5:0] >= 6'd32);
      sl[i*6 +: 6] = (f != ASMR_FMT_TDM && model[i][5:0] >= 6'd32)
                     ? model[i][5:0] - 6'd32 : model[i][5:0];
    end
    return {ln, rh, sl};
  endfunction : exp_dec

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask : check

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Write one byte, model keeps only page 0 mapped addresses
  task automatic wr(input logic [7:0] pg, input logic [7:0] a,
                    input logic [7:0] d);
    page_sel = pg;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    if (pg == 8'h00 && a >= 8'h0d && a <= 8'h10)
      model[a - 8'h0d] = d & 8'h7f;
  endtask : wr

  // Read one byte and compare, other pages and unmapped reads give zero
  task automatic rd(input logic [7:0] pg, input logic [7:0] a);
    page_sel = pg;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    if (pg == 8'h00 && a >= 8'h0d && a <= 8'h10)
      check(reg_rdata, model[a - 8'h0d]);
    else
      check(reg_rdata, 8'h00);
  endtask : rd

  // Reset, then reset values and decoded placement
  task automatic do_reset();
    rst = 1'b1;
    fmt = ASMR_FMT_TDM;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    model = '{ASMR_CH3_RESET, ASMR_CH4_RESET, ASMR_CH5_RESET,
              ASMR_CH6_RESET};
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h00, 8'h0d + 8'(i));
    end
    check({line_sel, right_half, slot_num}, exp_dec(fmt));
  endtask : do_reset

  // Main sequence: corners first, then random traffic, mid-run reset
  initial
  begin
    seed = 32'd70;
    err_count = 0;
    n_tests = 0;
    page_sel = 8'h00;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    do_reset();
    for (int k = 0; k < 400; k++)
    begin
      r = xs();
      if (k == 200)
        do_reset();
      fmt = asmr_fmt_t'(r[17:16]);
      if (k < 8)
        wr(8'h00, 8'h0d + 8'(k % 4), k[0] ? 8'hff : 8'h20 + 8'(k));
      else
        wr(r[5:3] == 3'h0 ? {r[15:9], 1'b1} : 8'h00, 8'h0c + r[2:0],
           r[31:24]);
      rd(r[20:18] == 3'h0 ? 8'h03 : 8'h00, 8'h0c + r[2:0]);
      check({line_sel, right_half, slot_num}, exp_dec(fmt));
    end
    tally_and_finish();
  end
endmodule : asmr_slot_map_regs_bench
